// ### hw/msc_pkg.sv
// msc_pkg: register map, field layout and encodings for the motion sync/compare block.
// assumes one aclk domain; registers are word-indexed, byte address = 4 * index.
package msc_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] MSC_IDX_MOTION_MODE   = 8'h07;
  localparam logic [7:0] MSC_IDX_AX0_VEL_LIMIT = 8'h21;
  localparam logic [7:0] MSC_IDX_AX0_TARGET    = 8'h28;
  localparam logic [7:0] MSC_IDX_AX0_PREG      = 8'h2D;
  localparam logic [7:0] MSC_IDX_AX1_VEL_LIMIT = 8'h56;
  localparam logic [7:0] MSC_IDX_AX1_TARGET    = 8'h5D;
  localparam logic [7:0] MSC_IDX_AX1_PREG      = 8'h62;
  localparam logic [7:0] MSC_IDX_CMP_POS       = 8'h70;
  localparam logic [7:0] MSC_IDX_CMP_REPEAT    = 8'h71;
  localparam logic [7:0] MSC_IDX_GLOBAL_CFG    = 8'h72;
  localparam logic [7:0] MSC_IDX_STATUS        = 8'h73;
  localparam logic [7:0] MSC_IDX_EFF_TARGET0   = 8'h74;
  localparam logic [7:0] MSC_IDX_EFF_TARGET1   = 8'h75;
  localparam logic [7:0] MSC_IDX_CORR_VEL0     = 8'h76;
  localparam logic [7:0] MSC_IDX_CORR_VEL1     = 8'h77;
  localparam int         MSC_IDX_LSB           = 2;
  localparam int         MSC_IDX_W             = 8;

  // ==========================================================================
  // motion mode register fields
  localparam int MSC_MODE0_LSB   = 0;
  localparam int MSC_MODE1_LSB   = 2;
  localparam int MSC_SYNC_BIT    = 8;
  localparam logic [31:0] MSC_MODE_RMASK = 32'h0000010F;

  // position regulator register fields
  localparam int MSC_GAIN_LSB    = 0;
  localparam int MSC_GAIN_W      = 10;
  localparam int MSC_TOL_LSB     = 16;
  localparam int MSC_TOL_W       = 8;
  localparam int MSC_TOLPOS_BIT  = 24;
  localparam logic [31:0] MSC_PREG_RESET = 32'h01000000;
  localparam logic [31:0] MSC_PREG_RMASK = 32'h01FF03FF;

  // global configuration step/dir select bits
  localparam int MSC_SD0_BIT = 13;
  localparam int MSC_SD1_BIT = 27;

  localparam int MSC_REPEAT_W = 24;

  // ==========================================================================
  // axis motion modes
  typedef enum logic [1:0]
  {
    MSC_MODE_POSITION = 2'b00,
    MSC_MODE_VEL_POS  = 2'b01,
    MSC_MODE_VEL_NEG  = 2'b10,
    MSC_MODE_HOLD     = 2'b11
  } msc_mode_t;

  localparam logic [1:0] MSC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'b10;
  localparam logic [31:0] MSC_ZERO       = 32'h00000000;

endpackage

// ### hw/msc_preg.sv
// msc_preg: one axis proportional position regulator with tolerance and clamp.
// assumes positions from the same aclk domain; output registered.
`timescale 1ns/1ps
`default_nettype none
module msc_preg
  import msc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // settings
  input  wire logic [31:0] preg_cfg,
  input  wire logic        stepdir_sel,
  input  wire logic [31:0] vel_limit,
  // feedback
  input  wire logic [31:0] ramp_pos,
  input  wire logic [31:0] enc_pos,
  input  wire logic        pos_reached,
  // result
  output var  logic [31:0] corr_vel,
  output var  logic        active
);

  logic [MSC_GAIN_W-1:0] gain;
  logic [MSC_TOL_W-1:0]  tol;
  logic                  tol_at_pos;
  logic signed [31:0]    err;
  logic [31:0]           mag;
  logic [41:0]           prod;
  logic                  en;
  logic                  ignore;
  logic [31:0]           corr_next;

  assign gain       = preg_cfg[MSC_GAIN_LSB +: MSC_GAIN_W];
  assign tol        = preg_cfg[MSC_TOL_LSB +: MSC_TOL_W];
  assign tol_at_pos = preg_cfg[MSC_TOLPOS_BIT];
  assign en         = (gain != '0) && !stepdir_sel;
  assign err        = $signed(ramp_pos - enc_pos);
  assign mag        = err[31] ? 32'(-err) : 32'(err);

  always_comb
  begin
    ignore    = (mag < {24'h000000, tol}) && (!tol_at_pos || pos_reached);
    prod      = 42'(mag) * 42'(gain);
    corr_next = MSC_ZERO;
    if (en && !ignore)
    begin
      // clamp magnitude before applying the sign
      if (prod > 42'(vel_limit[30:0]))
        corr_next = {1'b0, vel_limit[30:0]};
      else
        corr_next = prod[31:0];
      if (err[31])
        corr_next = 32'(-corr_next);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      corr_vel <= MSC_ZERO;
      active   <= 1'b0;
    end
    else
    begin
      corr_vel <= corr_next;
      active   <= en;
    end
  end

  chk_clamp_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    (corr_vel[31] ? 32'(-corr_vel) : corr_vel) <= {1'b0, $past(vel_limit[30:0])})
    else $error("corrective velocity above limit");
  chk_gain_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (gain == '0) |=> (corr_vel == MSC_ZERO))
    else $error("regulator active with zero gain");
  chk_stepdir_off: assert property (@(posedge aclk) disable iff (!aresetn)
    stepdir_sel |=> !active)
    else $error("regulator active in step/dir mode");
  chk_gain_unit: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && gain == 10'h001 && err == 32'sd5 && tol == 8'h00 && vel_limit > 32'h5)
      |=> corr_vel == 32'h00000005)
    else $error("unit gain does not give matching velocity");
  chk_tol_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tol_at_pos && mag < {24'h000000, tol}) |=> corr_vel == MSC_ZERO)
    else $error("error below tolerance not ignored");

endmodule
`default_nettype wire

// ### hw/msc_top.sv
// msc_top: position compare with repetition, synchronous axis start and
// per-axis position regulators, reached over AXI4-Lite.
// assumes the ramp generator supplies positions and direction on aclk.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module msc_top
  import msc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // ramp generator feedback
  input  wire logic [31:0] current_position0,
  input  wire logic [31:0] current_position1,
  input  wire logic        moving_negative0,
  input  wire logic [31:0] encoder_position0,
  input  wire logic [31:0] encoder_position1,
  input  wire logic        pos_reached0,
  input  wire logic        pos_reached1,
  // ramp generator controls
  output var  logic [1:0]  axis0_motion_mode,
  output var  logic [1:0]  axis1_motion_mode,
  output var  logic [31:0] axis0_velocity_limit,
  output var  logic [31:0] axis1_velocity_limit,
  output var  logic [31:0] axis0_eff_target,
  output var  logic [31:0] axis1_eff_target,
  output var  logic [31:0] axis0_corr_vel,
  output var  logic [31:0] axis1_corr_vel,
  // compare output, registered: high the cycle after current_position0 matches
  output var  logic        compare_out
);

  // ==========================================================================
  // register storage
  logic [31:0] mode_reg;
  logic [31:0] tgt0_reg;
  logic [31:0] tgt1_reg;
  logic [31:0] preg0_reg;
  logic [31:0] preg1_reg;
  logic [31:0] cmp_reg;
  logic [MSC_REPEAT_W-1:0] rep_reg;
  logic [31:0] gcfg_reg;
  logic        active0;
  logic        active1;

  function automatic logic [31:0] msc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [MSC_IDX_W-1:0] msc_index(input logic [31:0] addr);
    return addr[MSC_IDX_LSB +: MSC_IDX_W];
  endfunction

  // ==========================================================================
  // axi write channel: accept address and data in either order
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic [MSC_IDX_W-1:0] wr_idx;
  logic        wr_hit;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx  = msc_index(aw_addr_reg);

  always_comb
  begin
    case (wr_idx)
      MSC_IDX_MOTION_MODE, MSC_IDX_AX0_VEL_LIMIT, MSC_IDX_AX0_TARGET, MSC_IDX_AX0_PREG,
      MSC_IDX_AX1_VEL_LIMIT, MSC_IDX_AX1_TARGET, MSC_IDX_AX1_PREG, MSC_IDX_CMP_POS,
      MSC_IDX_CMP_REPEAT, MSC_IDX_GLOBAL_CFG: wr_hit = (aw_addr_reg[31:10] == '0);
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= MSC_ZERO;
      w_data_reg    <= MSC_ZERO;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= MSC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_mode;
  logic wr_tgt0;
  logic wr_tgt1;
  logic wr_cmp;
  logic [31:0] wr_val;
  logic [31:0] rep_merged;
  assign wr_mode = wr_fire && wr_hit && wr_idx == MSC_IDX_MOTION_MODE;
  assign wr_tgt0 = wr_fire && wr_hit && wr_idx == MSC_IDX_AX0_TARGET;
  assign wr_tgt1 = wr_fire && wr_hit && wr_idx == MSC_IDX_AX1_TARGET;
  assign wr_cmp  = wr_fire && wr_hit && wr_idx == MSC_IDX_CMP_POS;
  // repeat step is only 24 bits wide; merge on the full word, keep the low part
  assign rep_merged = msc_merge({8'h00, rep_reg}, w_data_reg, w_strb_reg);

  // ==========================================================================
  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg             <= MSC_ZERO;
      axis0_velocity_limit <= MSC_ZERO;
      axis1_velocity_limit <= MSC_ZERO;
      tgt0_reg             <= MSC_ZERO;
      tgt1_reg             <= MSC_ZERO;
      preg0_reg            <= MSC_PREG_RESET;
      preg1_reg            <= MSC_PREG_RESET;
      rep_reg              <= '0;
      gcfg_reg             <= MSC_ZERO;
    end
    else if (wr_fire && wr_hit)
    begin
      case (wr_idx)
        // both axis modes share one word so one write moves both
        MSC_IDX_MOTION_MODE:
          mode_reg <= msc_merge(mode_reg, w_data_reg, w_strb_reg) & MSC_MODE_RMASK;
        MSC_IDX_AX0_VEL_LIMIT:
          axis0_velocity_limit <= msc_merge(axis0_velocity_limit, w_data_reg, w_strb_reg);
        MSC_IDX_AX1_VEL_LIMIT:
          axis1_velocity_limit <= msc_merge(axis1_velocity_limit, w_data_reg, w_strb_reg);
        MSC_IDX_AX0_TARGET: tgt0_reg <= msc_merge(tgt0_reg, w_data_reg, w_strb_reg);
        MSC_IDX_AX1_TARGET: tgt1_reg <= msc_merge(tgt1_reg, w_data_reg, w_strb_reg);
        MSC_IDX_AX0_PREG:
          preg0_reg <= msc_merge(preg0_reg, w_data_reg, w_strb_reg) & MSC_PREG_RMASK;
        MSC_IDX_AX1_PREG:
          preg1_reg <= msc_merge(preg1_reg, w_data_reg, w_strb_reg) & MSC_PREG_RMASK;
        MSC_IDX_CMP_REPEAT:
          rep_reg <= rep_merged[MSC_REPEAT_W-1:0];
        MSC_IDX_GLOBAL_CFG: gcfg_reg <= msc_merge(gcfg_reg, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // motion modes to the ramp generators; hold/velocity/position decoded there
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      axis0_motion_mode <= MSC_MODE_POSITION;
      axis1_motion_mode <= MSC_MODE_POSITION;
    end
    else
    begin
      axis0_motion_mode <= mode_reg[MSC_MODE0_LSB +: 2];
      axis1_motion_mode <= mode_reg[MSC_MODE1_LSB +: 2];
    end
  end

  // ==========================================================================
  // effective targets: shadow axis0 while the joint commit bit is set.
  // in hold mode the ramp ignores targets, so hold-then-position starts both together.
  assign wr_val = msc_merge(tgt1_reg, w_data_reg, w_strb_reg);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      axis0_eff_target <= MSC_ZERO;
      axis1_eff_target <= MSC_ZERO;
    end
    else
    begin
      if (wr_tgt1)
      begin
        axis1_eff_target <= wr_val;
        if (mode_reg[MSC_SYNC_BIT])
          axis0_eff_target <= tgt0_reg;
      end
      if (wr_tgt0 && !mode_reg[MSC_SYNC_BIT])
        axis0_eff_target <= msc_merge(tgt0_reg, w_data_reg, w_strb_reg);
    end
  end

  // ==========================================================================
  // position compare with repetition
  logic match;
  logic match_q;
  logic leave;
  logic cmp_write_event;

  assign match           = (current_position0 == cmp_reg);
  assign leave           = match_q && !match;
  assign cmp_write_event = wr_cmp && (rep_reg != '0)
                        && (msc_merge(cmp_reg, w_data_reg, w_strb_reg) == current_position0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_reg     <= MSC_ZERO;
      match_q     <= 1'b0;
      compare_out <= 1'b0;
    end
    else
    begin
      match_q     <= match && !wr_cmp;
      compare_out <= match;
      if (wr_cmp)
      begin
        // with a non-zero repeat step, a write landing on the current position counts as a compare event
        if (cmp_write_event)
          cmp_reg <= moving_negative0 ? msc_merge(cmp_reg, w_data_reg, w_strb_reg)
                                        - {8'h00, rep_reg}
                                      : msc_merge(cmp_reg, w_data_reg, w_strb_reg)
                                        + {8'h00, rep_reg};
        else
          cmp_reg <= msc_merge(cmp_reg, w_data_reg, w_strb_reg);
      end
      else if (leave && rep_reg != '0)
        cmp_reg <= moving_negative0 ? cmp_reg - {8'h00, rep_reg}
                                    : cmp_reg + {8'h00, rep_reg};
    end
  end

  // ==========================================================================
  // per-axis regulators
  msc_preg u_preg0
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .preg_cfg    (preg0_reg),
    .stepdir_sel (gcfg_reg[MSC_SD0_BIT]),
    .vel_limit   (axis0_velocity_limit),
    .ramp_pos    (current_position0),
    .enc_pos     (encoder_position0),
    .pos_reached (pos_reached0),
    .corr_vel    (axis0_corr_vel),
    .active      (active0)
  );

  msc_preg u_preg1
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .preg_cfg    (preg1_reg),
    .stepdir_sel (gcfg_reg[MSC_SD1_BIT]),
    .vel_limit   (axis1_velocity_limit),
    .ramp_pos    (current_position1),
    .enc_pos     (encoder_position1),
    .pos_reached (pos_reached1),
    .corr_vel    (axis1_corr_vel),
    .active      (active1)
  );

  // ==========================================================================
  // axi read channel
  logic [31:0] rd_val;
  logic [MSC_IDX_W-1:0] rd_idx;
  logic        rd_hit;
  assign rd_idx = msc_index(s_axi_araddr);

  always_comb
  begin
    rd_hit = (s_axi_araddr[31:10] == '0);
    case (rd_idx)
      MSC_IDX_MOTION_MODE:   rd_val = mode_reg;
      MSC_IDX_AX0_VEL_LIMIT: rd_val = axis0_velocity_limit;
      MSC_IDX_AX0_TARGET:    rd_val = tgt0_reg;
      MSC_IDX_AX0_PREG:      rd_val = preg0_reg;
      MSC_IDX_AX1_VEL_LIMIT: rd_val = axis1_velocity_limit;
      MSC_IDX_AX1_TARGET:    rd_val = tgt1_reg;
      MSC_IDX_AX1_PREG:      rd_val = preg1_reg;
      MSC_IDX_CMP_POS:       rd_val = cmp_reg;
      MSC_IDX_CMP_REPEAT:    rd_val = {8'h00, rep_reg};
      MSC_IDX_GLOBAL_CFG:    rd_val = gcfg_reg;
      MSC_IDX_STATUS:        rd_val = {28'h0000000, active1, active0, match_q, compare_out};
      MSC_IDX_EFF_TARGET0:   rd_val = axis0_eff_target;
      MSC_IDX_EFF_TARGET1:   rd_val = axis1_eff_target;
      MSC_IDX_CORR_VEL0:     rd_val = axis0_corr_vel;
      MSC_IDX_CORR_VEL1:     rd_val = axis1_corr_vel;
      default:
      begin
        rd_val = MSC_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= MSC_ZERO;
      s_axi_rresp   <= MSC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  chk_compare_level: assert property (@(posedge aclk) disable iff (!aresetn)
    match |=> compare_out)
    else $error("compare output low during match");
  chk_no_repeat_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (leave && rep_reg == '0 && !wr_cmp) |=> $stable(cmp_reg))
    else $error("compare position moved with zero repeat");
  chk_step_forward: assert property (@(posedge aclk) disable iff (!aresetn)
    (leave && !wr_cmp && !moving_negative0)
      |=> cmp_reg == $past(cmp_reg) + {8'h00, $past(rep_reg)})
    else $error("compare position not advanced");
  chk_step_backward: assert property (@(posedge aclk) disable iff (!aresetn)
    (leave && !wr_cmp && moving_negative0)
      |=> cmp_reg == $past(cmp_reg) - {8'h00, $past(rep_reg)})
    else $error("compare position not retreated");
  chk_write_event: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_write_event |=> cmp_reg != current_position0 || $changed(current_position0))
    else $error("write on current position not stepped");
  chk_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_tgt0 && !wr_tgt1 && mode_reg[MSC_SYNC_BIT]) |=> $stable(axis0_eff_target))
    else $error("shadowed target leaked");
  chk_joint_commit: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_tgt1 && mode_reg[MSC_SYNC_BIT]) |=> axis0_eff_target == tgt0_reg)
    else $error("joint commit missed axis0");
  chk_mode_together: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mode |=> ##2 (axis0_motion_mode == $past(mode_reg[MSC_MODE0_LSB +: 2])
                     && axis1_motion_mode == $past(mode_reg[MSC_MODE1_LSB +: 2])))
    else $error("axis modes not updated together");

  cov_repeat_step: cover property (@(posedge aclk) disable iff (!aresetn)
    leave && rep_reg > 24'h000001);
  cov_joint_commit: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_tgt1 && mode_reg[MSC_SYNC_BIT]);
  cov_hold_mode: cover property (@(posedge aclk) disable iff (!aresetn)
    axis0_motion_mode == MSC_MODE_HOLD && axis1_motion_mode == MSC_MODE_HOLD);
  cov_regulating: cover property (@(posedge aclk) disable iff (!aresetn)
    active0 && axis0_corr_vel != MSC_ZERO);

endmodule
`default_nettype wire

// ### test/test_msc_top.sv
// test_msc_top: self-checking bench for msc_top, register reads checked from a queue.
// assumes a single aclk domain; the bench stands in for the ramp generator and encoders.
`timescale 1ns/1ps
`default_nettype none
module test_msc_top;
  import msc_pkg::*;
  logic        aclk = 0, aresetn = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, axis0_motion_mode, axis1_motion_mode;
  logic [31:0] s_axi_rdata, axis0_velocity_limit, axis1_velocity_limit, axis0_eff_target;
  logic [31:0] axis1_eff_target, axis0_corr_vel, axis1_corr_vel, t0, t1;
  logic [31:0] current_position0 = 0, current_position1 = 0;
  logic [31:0] encoder_position0 = 0, encoder_position1 = 0;
  logic        moving_negative0 = 0, pos_reached0 = 0, pos_reached1 = 0, compare_out;
  int          miscompares = 0, check_count = 0;
  logic [33:0] rq [$];
  logic [31:0] tb [6][4];
  msc_top u_msc_top
  (
    .aclk (aclk), .aresetn (aresetn), .s_axi_awaddr (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb), .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp), .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready), .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready),
    .s_axi_rdata (s_axi_rdata), .s_axi_rresp (s_axi_rresp), .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready), .current_position0 (current_position0),
    .current_position1 (current_position1), .moving_negative0 (moving_negative0),
    .encoder_position0 (encoder_position0), .encoder_position1 (encoder_position1),
    .pos_reached0 (pos_reached0), .pos_reached1 (pos_reached1),
    .axis0_motion_mode (axis0_motion_mode), .axis1_motion_mode (axis1_motion_mode),
    .axis0_velocity_limit (axis0_velocity_limit),
    .axis1_velocity_limit (axis1_velocity_limit),
    .axis0_eff_target (axis0_eff_target), .axis1_eff_target (axis1_eff_target),
    .axis0_corr_vel (axis0_corr_vel), .axis1_corr_vel (axis1_corr_vel),
    .compare_out (compare_out)
  );
  always #50 aclk = ~aclk;
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(34'(s_axi_bresp), 34'(MSC_RESP_OKAY), "bresp");
  endtask
  // the expectation is queued; the monitor below pairs it with the returned beat
  task automatic rd(input logic [7:0] i, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask
  always @(posedge aclk)
    if (s_axi_rvalid === 1'b1 && rq.size() > 0) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "rd");
  // each position is held two edges so the stepped compare value settles
  task automatic walk(input logic [31:0] p0, input logic dn, input logic [31:0] h0,
                      input logic [31:0] h1, input logic [31:0] h2);
    logic [31:0] p;
    p = p0;
    repeat (10)
    begin
      @(posedge aclk);
      current_position0 <= p;
      @(posedge aclk);
      #1 chk(34'(compare_out), 34'(p == h0 || p == h1 || p == h2), "cmp");
      p = dn ? p - 32'h1 : p + 32'h1;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // watchdog: the full sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    summarize();
  end
  // ==========
  // main sequence
  initial
  begin
    void'($urandom(32'h5A35));
    tb = '{'{32'h1, 32'h64, 32'h0, 32'h5}, '{32'h60001, 32'h64, 32'h0, 32'h0},
           '{32'h1060001, 32'h64, 32'h0, 32'h5}, '{32'h1, 32'h3, 32'h0, 32'h3},
           '{32'h0, 32'h64, 32'h0, 32'h0}, '{32'h1, 32'h64, 32'h2000, 32'h0}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h2D, {MSC_RESP_OKAY, MSC_PREG_RESET});
    rd(8'h00, {MSC_RESP_SLVERR, MSC_ZERO});
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h07, 32'(m | ((3 - m) << 2)));
      @(posedge aclk);
      #1 chk(34'({axis1_motion_mode, axis0_motion_mode}), 34'(((3 - m) << 2) | m), "mode");
    end
    $display("test motion modes done");
    t0 = $urandom;
    t1 = $urandom;
    wr(8'h07, 32'hF);
    wr(8'h21, t0);
    wr(8'h56, t1);
    wr(8'h07, 32'h9);
    @(posedge aclk);
    #1 chk(34'({axis1_motion_mode, axis0_motion_mode}), 34'h9, "mode");
    chk(34'(axis0_velocity_limit), 34'(t0), "vel0");
    chk(34'(axis1_velocity_limit), 34'(t1), "vel1");
    $display("test joint velocity done");
    wr(8'h07, 32'h100);
    t0 = $urandom;
    t1 = $urandom;
    wr(8'h28, t0);
    rd(8'h74, {MSC_RESP_OKAY, MSC_ZERO});
    wr(8'h5D, t1);
    rd(8'h74, {MSC_RESP_OKAY, t0});
    rd(8'h75, {MSC_RESP_OKAY, t1});
    chk(34'(axis0_eff_target), 34'(t0), "eff0");
    chk(34'(axis1_eff_target), 34'(t1), "eff1");
    $display("test joint target done");
    t0 = $urandom & 32'hFFFF;
    encoder_position0 <= t0;
    current_position0 <= t0 + 32'h5;
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h2D, tb[k][0]);
      wr(8'h21, tb[k][1]);
      wr(8'h72, tb[k][2]);
      rd(8'h76, {MSC_RESP_OKAY, tb[k][3]});
    end
    rd(8'h62, {MSC_RESP_OKAY, MSC_PREG_RESET});
    encoder_position1 <= t0;
    current_position1 <= t0 - 32'h5;
    wr(8'h62, 32'h1);
    wr(8'h56, 32'h64);
    rd(8'h77, {MSC_RESP_OKAY, 32'hFFFFFFFB});
    $display("test regulator done");
    wr(8'h71, 32'h0);
    current_position0 <= 32'h0;
    wr(8'h70, 32'hA);
    wr(8'h71, 32'h3);
    walk(32'h8, 1'b0, 32'hA, 32'hD, 32'h10);
    // reversing: repetition off, compare rewritten on the current position, then re-enabled
    wr(8'h71, 32'h0);
    moving_negative0 <= 1'b1;
    current_position0 <= 32'h20;
    wr(8'h70, 32'h20);
    rd(8'h70, {MSC_RESP_OKAY, 32'h00000020});
    wr(8'h71, 32'h3);
    walk(32'h1F, 1'b1, 32'h1D, 32'h1A, 32'h17);
    wr(8'h70, 32'h16);
    rd(8'h70, {MSC_RESP_OKAY, 32'h00000013});
    $display("test compare repeat done");
    summarize();
  end
endmodule
`default_nettype wire
